// *** inc/tcm_pkg.sv ***
// Constants and types shared by the transmit clock mode logic
package tcm_pkg;
    // System clock period
    localparam int CLK_SYS_NS = 25;
    // Transmit clock low for this long means the clock has stopped low
    localparam int LOW_HOLD_NS = 1000;
    localparam int LOW_HOLD_CYC_I = (LOW_HOLD_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
    // Master clock without an edge for this long counts as static
    localparam int MSTATIC_NS = 2000;
    localparam int MSTATIC_CYC_I = (MSTATIC_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;

    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] LOW_HOLD_CYC = CNT_W'(LOW_HOLD_CYC_I);
    localparam logic [CNT_W-1:0] MSTATIC_CYC = CNT_W'(MSTATIC_CYC_I);
    // Master cycles with the transmit clock high before all ones
    localparam logic [CNT_W-1:0] ALL_ONES_MCYC = 8'h10;
    // Transmit clock cycles of format select high before single rail
    localparam logic [CNT_W-1:0] FORMAT_TCYC = 8'h10;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

    // Symbol buffer
    localparam int SYM_W = 2;
    localparam int FIFO_DEPTH = 16;

    // Symbol codes, positive rail in the upper bit
    localparam logic [SYM_W-1:0] SYM_SPACE = 2'h0;
    localparam logic [SYM_W-1:0] SYM_NEG = 2'h1;
    localparam logic [SYM_W-1:0] SYM_POS = 2'h2;
    localparam logic [SYM_W-1:0] SYM_ILLEGAL = 2'h3;

    // Input synchroniser layout
    localparam int IN_W = 7;
    localparam int IN_TX_LINE_CLOCK = 0;
    localparam int IN_MCLK = 1;
    localparam int IN_POS = 2;
    localparam int IN_NEG = 3;
    localparam int IN_FMT = 4;
    localparam int IN_HOST = 5;
    localparam int IN_HAO = 6;

    // Transmitter behaviour chosen from the clock inputs
    typedef enum logic [2:0]
    {
        TCM_RUN,
        TCM_TRISTATE,
        TCM_ALL_ONES,
        TCM_NO_SHAPE
    } tcm_mode_t;
endpackage

// *** inc/tcm_stream_if.sv ***
// Valid/ready symbol stream through the transmit buffer
`timescale 1ns/100ps
interface tcm_stream_if #(parameter int W = 2);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;

    // Buffer side
    modport fifo (input in_valid, input in_data, input out_ready,
                  output in_ready, output out_valid, output out_data);
    // Producer and consumer side
    modport user (output in_valid, output in_data, output out_ready,
                  input in_ready, input out_valid, input out_data);
endinterface

// *** hdl/tcm_sync.sv ***
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/100ps
module tcm_sync #(parameter int W = 1)
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Asynchronous in, synchronised out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // One pair of flops per bit; first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    meta_ff[i] <= 1'b0;
                    sync_ff[i] <= 1'b0;
                end
                else
                begin
                    meta_ff[i] <= d[i];
                    sync_ff[i] <= meta_ff[i];
                end
            end
        end
    endgenerate

    assign q = sync_ff;
endmodule

// *** hdl/tcm_fifo.sv ***
// Parameterised symbol FIFO with valid/ready on both sides
`timescale 1ns/100ps
module tcm_fifo #(parameter int WIDTH = 2, parameter int DEPTH = 16)
(
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst_n,
    // Stream
    tcm_stream_if.fifo st
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ff;
    logic [AW:0]      rd_ff;
    logic [AW:0]      nxt_wr;
    logic [AW:0]      nxt_rd;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    // Extra pointer bit tells full from empty
    assign empty = (wr_ff == rd_ff);
    assign full = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
    assign push = st.in_valid && !full;
    assign pop = st.out_ready && !empty;
    assign st.in_ready = !full;
    assign st.out_valid = !empty;
    assign st.out_data = mem[rd_ff[AW-1:0]];

    // Pointer advance
    always_comb
    begin
        nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
        nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ff <= '0;
            rd_ff <= '0;
        end
        else
        begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
        end
    end

    // Storage carries no reset; only written slots are ever read
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ff[AW-1:0]] <= st.in_data;
        end
    end
endmodule

// *** hdl/tcm_top.sv ***
// Transmit clock mode detection, rail sampling and line symbol output
// Summary of operation
// - Hardware mode, running clock: sample both rails (dual) or the positive rail (single) on each falling edge.
// - Transmit clock held low: drivers go to low-power high impedance.
// - Clock high over 16 toggling master cycles: send all ones.
// - Clock high with static master clock: switch pulse shaping off.
// - Host mode: all ones chosen by a control input, not clock.
// - All-ones pattern is paced by the master reference clock.
// - Dual rail: 00 space, 01 negative, 10 positive, 11 illegal space.
// - Format select high 16 transmit clocks gives single rail; low dual.
`timescale 1ns/100ps
module tcm_top
    import tcm_pkg::*;
(
    // System clock and reset
    input  wire logic CLK_SYS,
    input  wire logic RST_N,
    // Pins from the framer
    input  wire logic TX_LINE_CLOCK,
    input  wire logic TX_POSITIVE_RAIL,
    input  wire logic TX_NEGATIVE_RAIL,
    input  wire logic RAIL_FORMAT_SELECT,
    input  wire logic MASTER_REF_CLOCK,
    // Control mode
    input  wire logic HOST_MODE,
    input  wire logic HOST_TRANSMIT_ALL_ONES,
    // Line driver side
    output logic      LINE_POS,
    output logic      LINE_NEG,
    output logic      LINE_OE,
    // Status
    output logic      TRANSMIT_ALL_ONES,
    output logic      SHAPING_ON,
    output logic      SINGLE_RAIL,
    output logic      ILLEGAL_SEEN,
    output logic      FIFO_OVERRUN
);
    logic [IN_W-1:0]  in_s;
    logic             tx_line_clock_s;
    logic             mclk_s;
    logic             host_s;
    logic             tx_line_clock_d_ff;
    logic             mclk_d_ff;
    logic             tx_line_clock_fall;
    logic             tx_line_clock_rise;
    logic             mclk_rise;
    logic             mclk_edge;
    logic [CNT_W-1:0] low_cnt_ff;
    logic [CNT_W-1:0] nxt_low_cnt;
    logic [CNT_W-1:0] thigh_cnt_ff;
    logic [CNT_W-1:0] nxt_thigh_cnt;
    logic [CNT_W-1:0] mhigh_cnt_ff;
    logic [CNT_W-1:0] nxt_mhigh_cnt;
    logic [CNT_W-1:0] mstatic_cnt_ff;
    logic [CNT_W-1:0] nxt_mstatic_cnt;
    logic [CNT_W-1:0] fmt_cnt_ff;
    logic [CNT_W-1:0] nxt_fmt_cnt;
    logic             single_ff;
    logic             nxt_single;
    tcm_mode_t        mode;
    logic             all_ones;
    logic             pol_ff;
    logic             nxt_pol;
    logic             pos_ff;
    logic             nxt_pos;
    logic             neg_ff;
    logic             nxt_neg;
    logic             oe_ff;
    logic             ao_ff;
    logic             shape_ff;
    logic             ill_ff;
    logic             nxt_ill;
    logic             ovr_ff;

    tcm_stream_if #(.W(SYM_W)) st ();

    // Every pin input is synchronised before use
    tcm_sync #(.W(IN_W)) u_sync
    (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .d     ({HOST_TRANSMIT_ALL_ONES, HOST_MODE, RAIL_FORMAT_SELECT,
                 TX_NEGATIVE_RAIL, TX_POSITIVE_RAIL, MASTER_REF_CLOCK,
                 TX_LINE_CLOCK}),
        .q     (in_s)
    );

    assign tx_line_clock_s = in_s[IN_TX_LINE_CLOCK];
    assign mclk_s = in_s[IN_MCLK];
    assign host_s = in_s[IN_HOST];
    assign tx_line_clock_fall = tx_line_clock_d_ff && !tx_line_clock_s;
    assign tx_line_clock_rise = !tx_line_clock_d_ff && tx_line_clock_s;
    assign mclk_rise = !mclk_d_ff && mclk_s;
    assign mclk_edge = mclk_d_ff != mclk_s;

    // Saturating increment keeps long holds from wrapping
    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v,
                                                 input logic [CNT_W-1:0] lim);
        sat_inc = (v >= lim) ? lim : v + 1'b1;
    endfunction

    // Clock activity counters
    always_comb
    begin
        nxt_low_cnt = tx_line_clock_s ? CNT_ZERO : sat_inc(low_cnt_ff, LOW_HOLD_CYC);
        nxt_thigh_cnt = tx_line_clock_s ? sat_inc(thigh_cnt_ff, MSTATIC_CYC) : CNT_ZERO;
        nxt_mstatic_cnt = mclk_edge ? CNT_ZERO
                          : sat_inc(mstatic_cnt_ff, MSTATIC_CYC);
        if (!tx_line_clock_s)
        begin
            nxt_mhigh_cnt = CNT_ZERO;
        end
        else if (mclk_rise)
        begin
            nxt_mhigh_cnt = sat_inc(mhigh_cnt_ff, ALL_ONES_MCYC + 1'b1);
        end
        else
        begin
            nxt_mhigh_cnt = mhigh_cnt_ff;
        end
    end

    // Format select is counted in transmit clock cycles
    always_comb
    begin
        nxt_fmt_cnt = fmt_cnt_ff;
        nxt_single = single_ff;
        if (!in_s[IN_FMT])
        begin
            nxt_fmt_cnt = CNT_ZERO;
            nxt_single = 1'b0;
        end
        else if (tx_line_clock_rise)
        begin
            nxt_fmt_cnt = sat_inc(fmt_cnt_ff, FORMAT_TCYC);
            if (nxt_fmt_cnt == FORMAT_TCYC)
            begin
                nxt_single = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            tx_line_clock_d_ff <= 1'b0;
            mclk_d_ff <= 1'b0;
            low_cnt_ff <= CNT_ZERO;
            thigh_cnt_ff <= CNT_ZERO;
            mhigh_cnt_ff <= CNT_ZERO;
            mstatic_cnt_ff <= CNT_ZERO;
            fmt_cnt_ff <= CNT_ZERO;
            single_ff <= 1'b0;
        end
        else
        begin
            tx_line_clock_d_ff <= tx_line_clock_s;
            mclk_d_ff <= mclk_s;
            low_cnt_ff <= nxt_low_cnt;
            thigh_cnt_ff <= nxt_thigh_cnt;
            mhigh_cnt_ff <= nxt_mhigh_cnt;
            mstatic_cnt_ff <= nxt_mstatic_cnt;
            fmt_cnt_ff <= nxt_fmt_cnt;
            single_ff <= nxt_single;
        end
    end

    // Clock-state decisions apply only under hardware control
    always_comb
    begin
        if (host_s)
        begin
            mode = TCM_RUN;
        end
        else if (low_cnt_ff == LOW_HOLD_CYC)
        begin
            mode = TCM_TRISTATE;
        end
        else if (mhigh_cnt_ff > ALL_ONES_MCYC)
        begin
            mode = TCM_ALL_ONES;
        end
        else if (thigh_cnt_ff == MSTATIC_CYC && mstatic_cnt_ff == MSTATIC_CYC)
        begin
            mode = TCM_NO_SHAPE;
        end
        else
        begin
            mode = TCM_RUN;
        end
        all_ones = host_s ? in_s[IN_HAO] : (mode == TCM_ALL_ONES);
    end

    // Rails captured on the falling transmit edge; the pins cannot be
    // stalled, so a full buffer drops the symbol and flags an overrun
    assign st.in_valid = tx_line_clock_fall;
    assign st.in_data = single_ff ? (in_s[IN_POS] ? SYM_POS : SYM_SPACE)
                        : {in_s[IN_POS], in_s[IN_NEG]};
    assign st.out_ready = mclk_rise && !all_ones;

    tcm_fifo #(.WIDTH(SYM_W), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .st    (st.fifo)
    );

    // Line symbols leave at the master clock rate
    always_comb
    begin
        nxt_pos = pos_ff;
        nxt_neg = neg_ff;
        nxt_pol = pol_ff;
        nxt_ill = 1'b0;
        if (mode == TCM_TRISTATE)
        begin
            nxt_pos = 1'b0;
            nxt_neg = 1'b0;
        end
        else if (mclk_rise && all_ones)
        begin
            nxt_pos = pol_ff;
            nxt_neg = !pol_ff;
            nxt_pol = !pol_ff;
        end
        else if (mclk_rise)
        begin
            nxt_pos = 1'b0;
            nxt_neg = 1'b0;
            if (st.out_valid)
            begin
                case (st.out_data)
                    SYM_NEG:
                    begin
                        nxt_neg = 1'b1;
                    end
                    SYM_POS:
                    begin
                        // Single rail marks alternate polarity
                        nxt_pos = single_ff ? pol_ff : 1'b1;
                        nxt_neg = single_ff ? !pol_ff : 1'b0;
                        nxt_pol = single_ff ? !pol_ff : pol_ff;
                    end
                    SYM_ILLEGAL:
                    begin
                        nxt_ill = 1'b1;
                    end
                    default:
                    begin
                        nxt_pos = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            pos_ff <= 1'b0;
            neg_ff <= 1'b0;
            pol_ff <= 1'b1;
            oe_ff <= 1'b0;
            ao_ff <= 1'b0;
            shape_ff <= 1'b1;
            ill_ff <= 1'b0;
            ovr_ff <= 1'b0;
        end
        else
        begin
            pos_ff <= nxt_pos;
            neg_ff <= nxt_neg;
            pol_ff <= nxt_pol;
            oe_ff <= (mode != TCM_TRISTATE);
            ao_ff <= all_ones;
            shape_ff <= (mode != TCM_NO_SHAPE);
            ill_ff <= nxt_ill;
            ovr_ff <= tx_line_clock_fall && !st.in_ready;
        end
    end

    assign LINE_POS = pos_ff;
    assign LINE_NEG = neg_ff;
    assign LINE_OE = oe_ff;
    assign TRANSMIT_ALL_ONES = ao_ff;
    assign SHAPING_ON = shape_ff;
    assign SINGLE_RAIL = single_ff;
    assign ILLEGAL_SEEN = ill_ff;
    assign FIFO_OVERRUN = ovr_ff;

    // Checks next to the logic
    a_rail_capture: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        tx_line_clock_fall && st.in_ready && !single_ff
        |=> u_fifo.wr_ff == $past(u_fifo.wr_ff) + 1'b1)
        else $error("falling edge did not store a symbol");
    a_low_tristate: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !host_s && low_cnt_ff == LOW_HOLD_CYC |=> !LINE_OE ##0 !LINE_POS)
        else $error("drivers not released with clock held low");
    a_all_ones_enter: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !host_s && low_cnt_ff != LOW_HOLD_CYC && mhigh_cnt_ff > ALL_ONES_MCYC
        |=> TRANSMIT_ALL_ONES)
        else $error("all ones not entered after master cycles");
    a_no_all_ones_early: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !host_s && mhigh_cnt_ff <= ALL_ONES_MCYC |=> !TRANSMIT_ALL_ONES)
        else $error("all ones entered too early");
    a_shaping_off: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        mode == TCM_NO_SHAPE |=> !SHAPING_ON)
        else $error("shaping kept on with static master clock");
    a_host_all_ones: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        host_s |=> TRANSMIT_ALL_ONES == $past(in_s[IN_HAO]) ##0 LINE_OE)
        else $error("host all-ones selection not followed");
    a_ao_pacing: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        all_ones && !mclk_rise && mode != TCM_TRISTATE |=> $stable(LINE_POS))
        else $error("all-ones output moved without master edge");
    a_illegal_space: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        mclk_rise && !all_ones && mode != TCM_TRISTATE && st.out_valid
        && st.out_data == SYM_ILLEGAL |=> !LINE_POS && !LINE_NEG && ILLEGAL_SEEN)
        else $error("illegal symbol not sent as space");
    a_dual_on_low: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !in_s[IN_FMT] |=> !SINGLE_RAIL)
        else $error("single rail kept with select low");
    a_single_after: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $rose(SINGLE_RAIL) |-> fmt_cnt_ff == FORMAT_TCYC)
        else $error("single rail taken before 16 clocks");
    a_count_clear: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !tx_line_clock_s |=> mhigh_cnt_ff == CNT_ZERO)
        else $error("master cycle count not cleared");
endmodule

// *** verif/tcm_framer_model.sv ***
// Framer model driving transmit clock, rails and master clock
`timescale 1ns/100ps
module tcm_framer_model
(
    // Control from the bench: 0 run, 1 hold low, 2 hold high
    input  wire logic [1:0] tmode,
    input  wire logic       mrun,
    input  wire logic       mlevel,
    input  wire logic [1:0] nxt_rails,
    // Pins toward the transceiver
    output logic            tx_line_clock,
    output logic            mclk,
    output logic            pos,
    output logic            neg
);
    // Transmit clock of 200 ns, standing still when held
    initial
    begin
        tx_line_clock = 1'b0;
        {pos, neg} = 2'h0;
        forever
        begin
            #100;
            tx_line_clock = (tmode == 2'h0) ? ~tx_line_clock : (tmode == 2'h2);
        end
    end

    // Rails change on the rise so they are steady at the fall
    always @(posedge tx_line_clock)
    begin
        {pos, neg} <= (tmode == 2'h0) ? nxt_rails : 2'h0;
    end

    // Steady 195 ns master clock, phase unrelated; static on request
    initial
    begin
        mclk = 1'b0;
        #37;
        forever
        begin
            #97.5;
            mclk = mrun ? ~mclk : mlevel;
        end
    end
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the transmit clock mode block
`timescale 1ns/100ps
module testbench
    import tcm_pkg::*;
;
    logic       clk_sys, rst_n, fmt_sel, host_mode, host_ao;
    logic       mrun, mlevel, cmp_on, tx_line_clock, mclk, tx_positive_rail, tx_negative_rail;
    logic [1:0] tmode, gen, rails_next, last_mk, x;
    logic       line_pos, line_neg, line_oe, all_ones;
    logic       shaping_on, single_rail, ill_seen, ovr;
    logic [15:0] lfsr;
    logic [1:0] expq[$];
    int         num_errors, n_checks, n_ill, n_ill_seen, n_ovr;
    int         note_left, n_mk, cyc, i;

    tcm_top u_tcm_top
    (
        .CLK_SYS                (clk_sys),
        .RST_N                  (rst_n),
        .TX_LINE_CLOCK          (tx_line_clock),
        .TX_POSITIVE_RAIL       (tx_positive_rail),
        .TX_NEGATIVE_RAIL       (tx_negative_rail),
        .RAIL_FORMAT_SELECT     (fmt_sel),
        .MASTER_REF_CLOCK       (mclk),
        .HOST_MODE              (host_mode),
        .HOST_TRANSMIT_ALL_ONES (host_ao),
        .LINE_POS               (line_pos),
        .LINE_NEG               (line_neg),
        .LINE_OE                (line_oe),
        .TRANSMIT_ALL_ONES      (all_ones),
        .SHAPING_ON             (shaping_on),
        .SINGLE_RAIL            (single_rail),
        .ILLEGAL_SEEN           (ill_seen),
        .FIFO_OVERRUN           (ovr)
    );

    tcm_framer_model u_tcm_framer_model
    (
        .tmode     (tmode),
        .mrun      (mrun),
        .mlevel    (mlevel),
        .nxt_rails (rails_next),
        .tx_line_clock      (tx_line_clock),
        .mclk      (mclk),
        .pos       (tx_positive_rail),
        .neg       (tx_negative_rail)
    );

    // System clock, 25 ns
    initial
    begin
        clk_sys = 1'b0;
        forever
            #12.5 clk_sys = ~clk_sys;
    end

    function automatic logic [15:0] lfsr_step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Marks must alternate in polarity from one to the next
    function automatic logic alt_ok();
        logic [1:0] obs;
        obs = {line_pos, line_neg};
        alt_ok = (obs == SYM_POS || obs == SYM_NEG) && obs != last_mk;
        last_mk = obs;
    endfunction

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic cyc_wait(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask

    // Let the buffer empty; bounded so a stuck output shows up
    task automatic drain();
        int k;
        repeat (3) @(negedge tx_line_clock);
        for (k = 0; k < 400 && expq.size() > 0; k++)
            @(posedge clk_sys);
        cyc_wait(20);
        check("queue left", 8'h0, 8'(expq.size()));
        expq.delete();
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Note each sampled mark, then choose the next one
    always @(negedge tx_line_clock)
    begin
        // Format follows the select pin, not the generator, so a
        // generator change on this same edge cannot race the note
        if (rst_n && tmode == 2'h0 && note_left > 0)
        begin
            if (fmt_sel && tx_positive_rail)
                expq.push_back(2'h3);
            else if (!fmt_sel && (tx_positive_rail ^ tx_negative_rail))
                expq.push_back({tx_positive_rail, tx_negative_rail});
            if (!fmt_sel && tx_positive_rail && tx_negative_rail)
                n_ill++;
            if (gen != 2'h0)
                note_left--;
        end
        n_mk++;
        lfsr = lfsr_step(lfsr);
        case (gen)
            2'h0: rails_next = SYM_SPACE;
            2'h3: rails_next = (n_mk < 16) ? SYM_POS : SYM_SPACE;
            default: rails_next = lfsr[1:0];
        endcase
    end

    // Look at the line once settled after each master rise
    always @(posedge mclk)
    begin
        if (cmp_on)
        begin
            cyc_wait(5);
            if ({line_pos, line_neg} !== 2'h0)
            begin
                x = (expq.size() > 0) ? expq.pop_front() : 2'h0;
                if (x == 2'h3)
                    check("single mark", 8'h1, {7'h0, alt_ok()});
                else
                    check("line symbol", {6'h0, x}, {6'h0, line_pos, line_neg});
            end
        end
    end

    // Pulse counters and hang guard
    always @(posedge clk_sys)
    begin
        n_ill_seen += (ill_seen === 1'b1);
        n_ovr += (ovr === 1'b1);
        cyc++;
        if (cyc == 30000)
        begin
            num_errors++;
            give_verdict();
        end
    end

    initial
    begin
        {rst_n, fmt_sel, host_mode, host_ao, cmp_on} = 5'h00;
        {mrun, mlevel, tmode, gen, rails_next} = 8'h80;
        {num_errors, n_checks, n_ill, n_mk, cyc} = '0;
        lfsr = 16'h0001;
        last_mk = 2'h0;
        note_left = 100000;
        cyc_wait(5);
        check("oe in reset", 8'h0, {7'h0, line_oe});
        check("shaping in reset", 8'h1, {7'h0, shaping_on});
        rst_n = 1'b1;
        cyc_wait(10);
        // Random dual-rail stream, illegal symbols included
        cmp_on = 1'b1;
        gen = 2'h1;
        repeat (120) @(negedge tx_line_clock);
        gen = 2'h0;
        drain();
        check("illegal count", 8'(n_ill), 8'(n_ill_seen));
        // Single rail after 16 transmit clocks with select high
        @(negedge tx_line_clock);
        cyc_wait(1);
        fmt_sel = 1'b1;
        repeat (15) @(posedge tx_line_clock);
        cyc_wait(6);
        check("single early", 8'h0, {7'h0, single_rail});
        @(posedge tx_line_clock);
        cyc_wait(6);
        check("single rail", 8'h1, {7'h0, single_rail});
        last_mk = 2'h0;
        gen = 2'h2;
        repeat (80) @(negedge tx_line_clock);
        gen = 2'h0;
        drain();
        fmt_sel = 1'b0;
        cyc_wait(6);
        check("dual rail", 8'h0, {7'h0, single_rail});
        // Fill the buffer with the master stopped, then drain it; the
        // line clock pauses first so the buffer is empty when it stops
        tmode = 2'h2;
        cyc_wait(24);
        tmode = 2'h0;
        n_ovr = 0;
        mrun = 1'b0;
        note_left = FIFO_DEPTH;
        n_mk = 0;
        gen = 2'h3;
        wait (note_left == 0);
        cyc_wait(6);
        check("no overrun", 8'h0, 8'(n_ovr));
        @(negedge tx_line_clock);
        cyc_wait(6);
        check("overrun", 8'h1, 8'(n_ovr));
        gen = 2'h0;
        mrun = 1'b1;
        drain();
        cmp_on = 1'b0;
        // Clock held high with master running: all ones
        @(negedge tx_line_clock);
        tmode = 2'h2;
        @(posedge tx_line_clock);
        repeat (15) @(posedge mclk);
        cyc_wait(5);
        check("all ones early", 8'h0, {7'h0, all_ones});
        repeat (3) @(posedge mclk);
        cyc_wait(5);
        check("all ones", 8'h1, {7'h0, all_ones});
        last_mk = 2'h0;
        repeat (4)
        begin
            @(posedge mclk);
            cyc_wait(5);
            check("all ones mark", 8'h1, {7'h0, alt_ok()});
        end
        tmode = 2'h0;
        @(negedge tx_line_clock);
        cyc_wait(6);
        check("all ones end", 8'h0, {7'h0, all_ones});
        // Clock held high with master static low, then high
        for (i = 0; i < 2; i++)
        begin
            @(negedge tx_line_clock);
            {mlevel, mrun, tmode} = {i[0], 1'b0, 2'h2};
            @(posedge tx_line_clock);
            cyc_wait(70);
            check("shaping early", 8'h1, {7'h0, shaping_on});
            cyc_wait(20);
            check("shaping off", 8'h0, {7'h0, shaping_on});
            check("no all ones", 8'h0, {7'h0, all_ones});
            tmode = 2'h0;
            repeat (4) @(negedge tx_line_clock);
            cyc_wait(4);
            check("shaping back", 8'h1, {7'h0, shaping_on});
            mrun = 1'b1;
        end
        // Clock held low: drivers released after the hold time
        @(negedge tx_line_clock);
        tmode = 2'h1;
        cyc_wait(38);
        check("oe early", 8'h1, {7'h0, line_oe});
        cyc_wait(8);
        check("oe off", 8'h0, {7'h0, line_oe});
        check("line quiet", 8'h0, {6'h0, line_pos, line_neg});
        tmode = 2'h0;
        repeat (2) @(negedge tx_line_clock);
        cyc_wait(4);
        check("oe back", 8'h1, {7'h0, line_oe});
        // Host mode: all ones from the control input only
        host_mode = 1'b1;
        tmode = 2'h1;
        host_ao = 1'b1;
        cyc_wait(6);
        check("host all ones", 8'h1, {7'h0, all_ones});
        host_ao = 1'b0;
        cyc_wait(50);
        check("host all ones off", 8'h0, {7'h0, all_ones});
        check("host oe", 8'h1, {7'h0, line_oe});
        give_verdict();
    end
endmodule
